// ==== rtl/ppdd_decade.sv ====
`timescale 1ns/1ps
module ppdd_decade
   import ppdd_pkg::*;
(
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RESETN,
   // control
   input  wire logic             CLR,
   input  wire logic             LOAD,
   input  wire logic [DIG_W-1:0] LOAD_VAL,
   input  wire logic             STEP,
   // state
   output logic      [DIG_W-1:0] VAL,
   output logic      [DIG_W-1:0] STATE_N,
   output logic                  CARRY,
   output logic                  NINE_HIT
);

   logic [DIG_W-1:0] val_ff;
   logic [DIG_W-1:0] nxt_val;
   logic [DIG_W-1:0] inc_val;

   assign inc_val = (val_ff == NINE) ? ZERO : val_ff + 4'h1;
   assign nxt_val = CLR  ? ZERO :
                    LOAD ? LOAD_VAL :
                    STEP ? inc_val : val_ff;

   always_ff @(posedge CLK) begin
      if (!RESETN)
         val_ff <= ZERO;
      else
         val_ff <= nxt_val;
   end

   assign VAL      = val_ff;
   assign STATE_N  = ~val_ff;
   assign CARRY    = (val_ff >= CARRY_AT);
   assign NINE_HIT = (val_ff == NINE);

endmodule

// ==== rtl/ppdd_pkg.sv ====
package ppdd_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ       = 100;
   localparam int TMR_W         = 10;
   localparam int RESET_NS      = 1300;
   localparam int PRESET_NS     = 500;
   localparam int GATE_AROUND_NS = 1100;
   localparam int SYNC_INH_NS   = 7300;
   localparam int GATED_NS      = 200;
   localparam int RESET_CYC     = (RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int PRESET_CYC    = (PRESET_NS * CLK_MHZ + 999) / 1000;
   localparam int GA_CYC        = (GATE_AROUND_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_CYC      = (SYNC_INH_NS * CLK_MHZ + 999) / 1000;
   localparam int GATED_CYC     = (GATED_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // decades
   // ---------------------------------------------------------------
   localparam int          DIGITS   = 6;
   localparam int          DIG_W    = 4;
   localparam logic [3:0]  NINE     = 4'h9;
   localparam logic [3:0]  CARRY_AT = 4'h8;
   localparam logic [3:0]  ZERO     = 4'h0;

   // ---------------------------------------------------------------
   // register map (word indices, address bits 3:2)
   // ---------------------------------------------------------------
   localparam int          ADDR_W      = 4;
   localparam logic [1:0]  IDX_CTRL    = 2'h0;
   localparam logic [1:0]  IDX_DELAY   = 2'h1;
   localparam logic [1:0]  IDX_STATUS  = 2'h2;
   localparam logic [1:0]  IDX_PRESET  = 2'h3;
   localparam int          CTRL_FAST   = 0;
   localparam int          CTRL_STOP   = 1;
   localparam int          CTRL_SYNC   = 2;
   localparam logic [23:0] DELAY_RST   = 24'h000000;
   localparam int          ST_TICK_N   = 0;
   localparam int          ST_NINES    = 1;
   localparam int          ST_SYNC_INH = 2;
   localparam int          ST_SEQ      = 4;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_RESET  = 2'b01,
      SEQ_PRESET = 2'b11
   } ppdd_seq_e;

   typedef struct packed {
      logic sync_arm;
      logic stop;
      logic fast;
   } ppdd_ctrl_s;

   localparam ppdd_ctrl_s CTRL_RST = '{sync_arm: 1'b0, stop: 1'b0,
                                       fast: 1'b0};

endpackage

// ==== rtl/ppdd_top.sv ====
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module ppdd_top
   import ppdd_pkg::*;
(
   // clock and reset
   input  wire logic              CLK,
   input  wire logic              RESETN,
   // link
   input  wire logic              MHZ_IN,
   input  wire logic              SYNC_IN,
   // avalon slave
   input  wire logic [ppdd_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input  wire logic              AVS_READ,
   input  wire logic              AVS_WRITE,
   input  wire logic [31:0]       AVS_WRITEDATA,
   input  wire logic [3:0]        AVS_BYTEENABLE,
   output logic      [31:0]       AVS_READDATA,
   output logic                   AVS_WAITREQUEST,
   // outputs
   output logic                   PPS_OUT,
   output logic                   CLOCK_DRIVE_OUT,
   output logic                   NINES_N,
   output logic                   PRESET_N,
   output logic                   RESET_PULSE,
   output logic                   MASTER_TICK_N
);

   import ppdd_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   ppdd_ctrl_s        ctrl_ff;
   ppdd_ctrl_s        nxt_ctrl;
   logic [23:0]       delay_ff;
   logic [23:0]       nxt_delay;
   logic              ack_ff;
   logic [31:0]       rdata_ff;
   logic [31:0]       rd_mux;
   logic              bus_req;
   logic [1:0]        idx;
   logic              wr_ctrl;
   logic              wr_delay;

   logic              mhz_ff;
   logic              sync_ff;
   logic              mhz_rise;
   logic              sync_rise;
   logic              sync_go;
   logic [TMR_W-1:0]  gate_cnt_ff;
   logic [TMR_W-1:0]  nxt_gate_cnt;
   logic [TMR_W-1:0]  sync_cnt_ff;
   logic [TMR_W-1:0]  nxt_sync_cnt;
   logic              gated_pulse;
   logic              count_pulse;
   logic              sync_inh;

   logic [DIG_W-1:0]  m_val   [DIGITS];
   logic [DIGITS:0]   m_en;
   logic [DIGITS-1:0] m_carry;
   logic [DIGITS-1:0] m_nine;
   logic              tick_n;
   logic              tick_n_ff;
   logic              tick_fall;

   ppdd_seq_e         seq_ff;
   ppdd_seq_e         nxt_seq;
   logic [TMR_W-1:0]  seq_cnt_ff;
   logic [TMR_W-1:0]  nxt_seq_cnt;
   logic              rst_active;
   logic              pre_active;
   logic              inhibit;

   logic [DIG_W-1:0]  p_val   [DIGITS];
   logic [DIG_W-1:0]  p_load  [DIGITS];
   logic [DIGITS-1:0] dig_nine;
   logic [DIGITS:0]   p_en;
   logic [DIGITS-1:0] p_carry;
   logic [DIGITS-1:0] p_nine;
   logic [23:0]       p_flat;
   logic              all9_set;
   logic              p_load_en;
   logic              nines;
   logic              nines_ff;
   logic              nines_end;

   logic [TMR_W-1:0]  ga_cnt_ff;
   logic [TMR_W-1:0]  nxt_ga_cnt;
   logic              ga_active;
   logic              out_norm;
   logic              out_wrap;
   logic              out_any;
   logic              fast_pulse;
   logic              drive;

   // ---------------------------------------------------------------
   // avalon slave
   // ---------------------------------------------------------------
   assign bus_req         = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = bus_req & ~ack_ff;
   assign idx             = AVS_ADDRESS[3:2];
   assign wr_ctrl  = AVS_WRITE & ack_ff & (idx == IDX_CTRL);
   assign wr_delay = AVS_WRITE & ack_ff & (idx == IDX_DELAY);

   assign nxt_ctrl = (wr_ctrl & AVS_BYTEENABLE[0]) ?
                     ppdd_ctrl_s'{sync_arm: AVS_WRITEDATA[CTRL_SYNC],
                       stop:     AVS_WRITEDATA[CTRL_STOP],
                       fast:     AVS_WRITEDATA[CTRL_FAST]} : ctrl_ff;

   genvar b;
   generate
      for (b = 0; b < 3; b++) begin : g_lane
         assign nxt_delay[8*b +: 8] =
            (wr_delay & AVS_BYTEENABLE[b]) ? AVS_WRITEDATA[8*b +: 8]
                                           : delay_ff[8*b +: 8];
      end
   endgenerate

   always_comb begin
      rd_mux = 32'h00000000;
      case (idx)
         IDX_CTRL: begin
            rd_mux[CTRL_FAST] = ctrl_ff.fast;
            rd_mux[CTRL_STOP] = ctrl_ff.stop;
            rd_mux[CTRL_SYNC] = ctrl_ff.sync_arm;
         end
         IDX_DELAY: begin
            rd_mux[23:0] = delay_ff;
         end
         IDX_STATUS: begin
            rd_mux[ST_TICK_N]       = tick_n;
            rd_mux[ST_NINES]        = nines;
            rd_mux[ST_SYNC_INH]     = sync_inh;
            rd_mux[ST_SEQ +: 2]     = seq_ff;
         end
         IDX_PRESET: begin
            rd_mux[23:0] = p_flat;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
         ctrl_ff  <= CTRL_RST;
         delay_ff <= DELAY_RST;
      end else begin
         ack_ff   <= bus_req & ~ack_ff;
         rdata_ff <= (AVS_READ & ~ack_ff) ? rd_mux : rdata_ff;
         ctrl_ff  <= nxt_ctrl;
         delay_ff <= nxt_delay;
      end
   end

   assign AVS_READDATA = rdata_ff;

   // ---------------------------------------------------------------
   // gated 1 MHz pulser and sync inhibit
   // ---------------------------------------------------------------
   assign mhz_rise  = MHZ_IN & ~mhz_ff;
   assign sync_rise = SYNC_IN & ~sync_ff;
   assign sync_go   = sync_rise & ctrl_ff.sync_arm;
   assign sync_inh  = (sync_cnt_ff != '0);

   assign nxt_sync_cnt = sync_go  ? TMR_W'(SYNC_CYC) :
                         sync_inh ? sync_cnt_ff - 1'b1 : '0;
   assign nxt_gate_cnt =
      (mhz_rise & ~sync_inh & ~sync_go & (gate_cnt_ff == '0)) ?
         TMR_W'(GATED_CYC) :
      (gate_cnt_ff != '0) ? gate_cnt_ff - 1'b1 : '0;

   assign gated_pulse = (gate_cnt_ff != '0);
   assign count_pulse = (gate_cnt_ff == TMR_W'(1));

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         mhz_ff      <= 1'b0;
         sync_ff     <= 1'b0;
         gate_cnt_ff <= '0;
         sync_cnt_ff <= '0;
      end else begin
         mhz_ff      <= MHZ_IN;
         sync_ff     <= SYNC_IN;
         gate_cnt_ff <= nxt_gate_cnt;
         sync_cnt_ff <= nxt_sync_cnt;
      end
   end

   // ---------------------------------------------------------------
   // master counter, six decades
   // ---------------------------------------------------------------
   assign m_en[0] = count_pulse;

   genvar i;
   generate
      for (i = 0; i < DIGITS; i++) begin : g_master
         ppdd_decade u_dec (
            .CLK      (CLK),
            .RESETN   (RESETN),
            .CLR      (sync_go),
            .LOAD     (1'b0),
            .LOAD_VAL (ZERO),
            .STEP     (m_en[i]),
            .VAL      (m_val[i]),
            .STATE_N  (),
            .CARRY    (m_carry[i]),
            .NINE_HIT (m_nine[i])
         );
         assign m_en[i+1] = m_en[i] & m_carry[i] & m_nine[i];
      end
   endgenerate

   // top decade at zero for 100000 counts: 100 ms low tick
   assign tick_n    = (m_val[DIGITS-1] != ZERO);
   assign tick_fall = tick_n_ff & ~tick_n;

   // ---------------------------------------------------------------
   // reset and preset sequencer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_seq     = seq_ff;
      nxt_seq_cnt = seq_cnt_ff;
      case (seq_ff)
         SEQ_IDLE: begin
            if (tick_fall) begin
               nxt_seq     = SEQ_RESET;
               nxt_seq_cnt = TMR_W'(RESET_CYC);
            end
         end
         SEQ_RESET: begin
            if (seq_cnt_ff == TMR_W'(1)) begin
               nxt_seq     = SEQ_PRESET;
               nxt_seq_cnt = TMR_W'(PRESET_CYC);
            end else begin
               nxt_seq_cnt = seq_cnt_ff - 1'b1;
            end
         end
         SEQ_PRESET: begin
            if (seq_cnt_ff == TMR_W'(1)) begin
               nxt_seq     = SEQ_IDLE;
               nxt_seq_cnt = '0;
            end else begin
               nxt_seq_cnt = seq_cnt_ff - 1'b1;
            end
         end
         default: begin
            nxt_seq     = SEQ_IDLE;
            nxt_seq_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         seq_ff     <= SEQ_IDLE;
         seq_cnt_ff <= '0;
         tick_n_ff  <= 1'b1;
      end else begin
         seq_ff     <= nxt_seq;
         seq_cnt_ff <= nxt_seq_cnt;
         tick_n_ff  <= tick_n;
      end
   end

   assign rst_active = (seq_ff == SEQ_RESET);
   assign pre_active = (seq_ff == SEQ_PRESET);
   // setting 999999 runs in step with the master, so it is not held
   assign inhibit    = (rst_active | pre_active) & ~all9_set;

   // ---------------------------------------------------------------
   // preset counter, six decades
   // ---------------------------------------------------------------
   assign p_en[0]   = count_pulse & ~inhibit;
   assign p_load_en = pre_active & ~all9_set;
   assign all9_set  = &dig_nine;

   generate
      for (i = 0; i < DIGITS; i++) begin : g_preset
         logic [DIG_W-1:0] dig;
         assign dig         = delay_ff[DIG_W*i +: DIG_W];
         assign dig_nine[i] = (dig == NINE);
         // out-of-range digits load as zero complement
         assign p_load[i]   = (dig > NINE) ? ZERO : NINE - dig;
         assign p_flat[DIG_W*i +: DIG_W] = p_val[i];
         ppdd_decade u_dec (
            .CLK      (CLK),
            .RESETN   (RESETN),
            .CLR      (rst_active),
            .LOAD     (p_load_en),
            .LOAD_VAL (p_load[i]),
            .STEP     (p_en[i]),
            .VAL      (p_val[i]),
            .STATE_N  (),
            .CARRY    (p_carry[i]),
            .NINE_HIT (p_nine[i])
         );
         assign p_en[i+1] = p_en[i] & p_carry[i] & p_nine[i];
      end
   endgenerate

   // ---------------------------------------------------------------
   // nines detector and gate-around
   // ---------------------------------------------------------------
   // held until the next count pulse moves the first decade
   assign nines     = &p_nine;
   assign nines_end = nines_ff & ~nines;

   assign nxt_ga_cnt = (nines_end & all9_set) ? TMR_W'(GA_CYC) :
                       ga_active ? ga_cnt_ff - 1'b1 : '0;
   assign ga_active  = (ga_cnt_ff != '0);

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         nines_ff  <= 1'b0;
         ga_cnt_ff <= '0;
      end else begin
         nines_ff  <= nines;
         ga_cnt_ff <= nxt_ga_cnt;
      end
   end

   // ---------------------------------------------------------------
   // output gates
   // ---------------------------------------------------------------
   assign out_norm = nines & gated_pulse & ~all9_set;
   assign out_wrap = ga_active & rst_active & gated_pulse;
   assign out_any  = out_norm | out_wrap;

   assign fast_pulse = gated_pulse & p_en[DIGITS-1];
   assign drive = ctrl_ff.stop ? 1'b0 :
                  ctrl_ff.fast ? fast_pulse : out_any;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         PPS_OUT         <= 1'b0;
         CLOCK_DRIVE_OUT <= 1'b0;
         NINES_N         <= 1'b1;
         PRESET_N        <= 1'b1;
         RESET_PULSE     <= 1'b0;
         MASTER_TICK_N   <= 1'b1;
      end else begin
         PPS_OUT         <= out_any;
         CLOCK_DRIVE_OUT <= drive;
         NINES_N         <= ~nines;
         PRESET_N        <= ~pre_active;
         RESET_PULSE     <= rst_active;
         MASTER_TICK_N   <= tick_n;
      end
   end

endmodule

// ==== test/ppdd_mhz_src.sv ====
`timescale 1ns/1ps
module ppdd_mhz_src (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RESETN,
   // drive
   input  wire logic EN,
   output logic      MHZ
);
   logic [6:0] ph_ff;
   logic [6:0] nxt_ph;

   // ---------------------------------------------------------------
   // 1 MHz square wave, phase restarts with reset
   // ---------------------------------------------------------------
   assign nxt_ph = (ph_ff == 7'h63) ? 7'h00 : ph_ff + 7'h01;
   always_ff @(posedge CLK) begin
      ph_ff <= RESETN ? nxt_ph : 7'h00;
   end
   assign MHZ = EN && (ph_ff < 7'h32);
endmodule

// ==== test/ppdd_top_sva.sv ====
`timescale 1ns/1ps
module ppdd_top_sva (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // bus handshake
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   // timing outputs
   input wire logic PPS_OUT,
   input wire logic NINES_N,
   input wire logic PRESET_N,
   input wire logic RESET_PULSE,
   input wire logic MASTER_TICK_N
);
   logic [7:0]  rst_ff;
   logic [7:0]  pre_ff;
   logic [7:0]  pps_ff;
   logic [15:0] nin_ff;

   // ---------------------------------------------------------------
   // run lengths of the timed pulses
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      rst_ff <= (RESETN && RESET_PULSE) ? rst_ff + 8'h01 : 8'h00;
      pre_ff <= (RESETN && !PRESET_N) ? pre_ff + 8'h01 : 8'h00;
      pps_ff <= (RESETN && PPS_OUT) ? pps_ff + 8'h01 : 8'h00;
      nin_ff <= (RESETN && !NINES_N) ? nin_ff + 16'h0001 : 16'h0000;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   reset_width_a: assert property (
      $fell(RESET_PULSE) |-> rst_ff == 8'h82)
      else $error("reset pulse width wrong");
   preset_width_a: assert property (
      $rose(PRESET_N) |-> pre_ff == 8'h32)
      else $error("preset pulse width wrong");
   preset_follows_a: assert property (
      $fell(RESET_PULSE) |-> ##[0:1] !PRESET_N)
      else $error("preset did not follow reset");
   tick_starts_a: assert property (
      $fell(MASTER_TICK_N) |-> ##[0:2] RESET_PULSE)
      else $error("tick did not start reset");
   reset_blocks_a: assert property (
      RESET_PULSE && $past(RESET_PULSE, 2) |-> NINES_N)
      else $error("nines seen during reset");
   pps_gate_a: assert property (
      $rose(PPS_OUT) |-> !NINES_N || !$past(NINES_N) || RESET_PULSE)
      else $error("output without nines or wrap");
   pps_width_a: assert property (
      $fell(PPS_OUT) |-> pps_ff inside {[8'h13:8'h14]})
      else $error("output pulse width wrong");
   nines_width_a: assert property (
      $rose(NINES_N) |-> nin_ff <= 16'h0064)
      else $error("nines pulse too long");
   bus_wait_a: assert property (
      $rose(AVS_READ) || $rose(AVS_WRITE) |->
         AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("bus wait state wrong");
endmodule

// ==== test/preset_pps_delay_divider_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
   bad_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
   end end
module preset_pps_delay_divider_tb;
   import ppdd_pkg::*;
   localparam int LIMIT = 20000;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        en = 1'b0;
   logic        sync = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, q, q2, junk;
   logic        mhz, waitreq, pps, cdo, nines_n, pre_n, rst_p, tick_n;
   int          checks, bad_count, cyc, rw_cnt, pw_cnt, cd_cnt;
   int          t_pre, t_pps, dl[4];
   logic        pps_prev;
   logic [23:0] set_a [4] = '{24'h000001, 24'h000002, 24'h000000, 24'h123456};
   logic [23:0] run_d [4] = '{24'h000001, 24'h000003, 24'h000001, 24'h000001};
   logic [2:0]  run_c [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
   logic        run_e [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

   always #5 clk = ~clk;

   ppdd_top dut (
      .CLK(clk), .RESETN(rst_n), .MHZ_IN(mhz), .SYNC_IN(sync),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .PPS_OUT(pps), .CLOCK_DRIVE_OUT(cdo), .NINES_N(nines_n),
      .PRESET_N(pre_n), .RESET_PULSE(rst_p), .MASTER_TICK_N(tick_n));
   ppdd_mhz_src u_src (.CLK(clk), .RESETN(rst_n), .EN(en), .MHZ(mhz));

   // ---------------------------------------------------------------
   // monitors and watchdog
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      if (rst_p === 1'b1) rw_cnt++;
      if (pre_n === 1'b0) pw_cnt++;
      if (pre_n === 1'b0) t_pre = cyc;
      if (pps === 1'b1 && pps_prev !== 1'b1) t_pps = cyc;
      if (cdo === 1'b1) cd_cnt++;
      pps_prev = pps;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one request held until waitrequest is seen low at an edge
   task automatic av_xfer(input logic w, input logic [3:0] a,
                          input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      // waitrequest and read data are the values standing at this edge
      do @(posedge clk); while (waitreq !== 1'b0);
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic do_reset(input logic [23:0] d, input logic [2:0] c);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rw_cnt = 0;
      pw_cnt = 0;
      cd_cnt = 0;
      t_pps = 0;
      rst_n <= 1'b1;
      av_xfer(1'b1, 4'h4, {8'h00, d}, junk);
      av_xfer(1'b1, 4'h0, {29'h0, c}, junk);
   endtask

   function automatic logic [23:0] nines_c(input logic [23:0] s);
      for (int i = 0; i < 6; i++)
         nines_c[4*i +: 4] = 4'h9 - s[4*i +: 4];
   endfunction

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      av_xfer(1'b0, 4'h0, 32'h0, q);
      `CHK("ctrl_reset", 32'h0, q)
      av_xfer(1'b0, 4'h4, 32'h0, q);
      `CHK("delay_reset", 32'h0, q)
      `CHK("tick_low", 1'b0, tick_n)
      av_xfer(1'b1, 4'h0, 32'hFFFFFFFF, junk);
      av_xfer(1'b0, 4'h0, 32'h0, q);
      `CHK("ctrl_bits", 32'h7, q)
      $display("test registers done");

      for (int i = 0; i < 4; i++) begin
         do_reset(set_a[i], 3'h0);
         av_xfer(1'b0, 4'h8, 32'h0, q);
         `CHK("seq_reset", 2'b01, q[5:4])
         while (pw_cnt == 0 || pre_n !== 1'b1) @(posedge clk);
         `CHK("reset_width", 130, rw_cnt)
         `CHK("preset_width", 50, pw_cnt)
         av_xfer(1'b1, 4'hC, 32'h0, junk);
         av_xfer(1'b0, 4'hC, 32'h0, q);
         `CHK("preset_val", {8'h00, nines_c(set_a[i])}, q)
         `CHK("nines_idle", (set_a[i] != 24'h0), nines_n)
      end
      $display("test preset load done");

      en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         do_reset(run_d[i], run_c[i]);
         while (t_pps == 0) @(posedge clk);
         `CHK("nines_at_out", 1'b0, nines_n)
         dl[i] = t_pps - t_pre;
         repeat (40) @(posedge clk);
         av_xfer(1'b0, 4'hC, 32'h0, q);
         `CHK("wrap_zero", 32'h0, q)
         `CHK("clock_drive", run_e[i], (cd_cnt > 0))
      end
      `CHK("step_delay", 200, dl[1] - dl[0])
      $display("test output timing done");

      do_reset(24'h000001, 3'h4);
      while (t_pps == 0) @(posedge clk);
      sync <= 1'b1;
      repeat (3) @(posedge clk);
      av_xfer(1'b0, 4'h8, 32'h0, q);
      `CHK("sync_inh_on", 1'b1, q[2])
      // gated pulse already running at sync still counts once
      repeat (30) @(posedge clk);
      av_xfer(1'b0, 4'hC, 32'h0, q);
      repeat (300) @(posedge clk);
      av_xfer(1'b0, 4'hC, 32'h0, q2);
      `CHK("held_count", q, q2)
      repeat (450) @(posedge clk);
      av_xfer(1'b0, 4'h8, 32'h0, q);
      `CHK("sync_inh_off", 1'b0, q[2])
      repeat (250) @(posedge clk);
      av_xfer(1'b0, 4'hC, 32'h0, q);
      `CHK("count_resumes", 1'b1, (q !== q2))
      av_xfer(1'b1, 4'h0, 32'h0, junk);
      sync <= 1'b0;
      repeat (2) @(posedge clk);
      sync <= 1'b1;
      repeat (3) @(posedge clk);
      av_xfer(1'b0, 4'h8, 32'h0, q);
      `CHK("sync_unarmed", 1'b0, q[2])
      $display("test sync done");
      report_and_stop();
   end
endmodule

bind ppdd_top ppdd_top_sva u_sva (
   .CLK(CLK), .RESETN(RESETN), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .PPS_OUT(PPS_OUT), .NINES_N(NINES_N), .PRESET_N(PRESET_N),
   .RESET_PULSE(RESET_PULSE), .MASTER_TICK_N(MASTER_TICK_N));
